/* hdl/dxh_exception.sv */
// Exception handling and command filtering for the satellite sensor.
`timescale 1ns/1ps
`include "dxh_cfg.svh"
module dxh_exception
#(
    parameter int RSV_PERIOD_CYC = `DXH_US_TO_CYC(`DXH_RSV_PERIOD_US),
    parameter int CAP_PERIOD_CYC = `DXH_US_TO_CYC(`DXH_CAP_PERIOD_US),
    parameter int TO_PERIOD_CYC  = `DXH_US_TO_CYC(`DXH_TO_PERIOD_US)
)
(
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             cmd_valid,
    input  wire logic             cmd_downstream,
    input  wire logic [3:0]       cmd_id,
    input  wire logic [3:0]       cmd_addr,
    input  wire logic             cmd_short,
    input  wire logic [3:0]       dev_addr,
    input  wire logic             dreg_low_n,
    input  wire logic             areg_low_n,
    input  wire logic             reserve_cap_pin,
    input  wire logic             upstream_bus_pin,
    input  wire logic             cap_test_fail,
    input  wire logic             factory_crc_fail,
    input  wire logic             factory_sealed,
    input  wire logic             user_crc_fail,
    input  wire logic             user_sealed,
    input  wire logic             temp_out_of_range,
    input  wire logic [3:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    output logic                  irq,
    output logic                  cmd_accept,
    output logic                  resp_enable,
    output logic                  error_flag,
    output logic                  selfcheck_on_flag,
    output logic                  reserve_low_flag,
    output dxh_pkg::dxh_dsel_t    acc_data_sel,
    output logic                  selftest_drive,
    output logic                  bus_switch_close,
    output logic                  core_reset
);
    import dxh_pkg::*;

    // Active-low regulator sense lines and level pins are synchronised first.
    logic dreg_ok;
    logic areg_ok;
    logic cap_ok;
    logic bus_high;
    dxh_sync u_s_dreg (.mclk(mclk), .rst(rst), .din(dreg_low_n), .dout(dreg_ok));
    dxh_sync u_s_areg (.mclk(mclk), .rst(rst), .din(areg_low_n), .dout(areg_ok));
    dxh_sync u_s_cap  (.mclk(mclk), .rst(rst), .din(reserve_cap_pin), .dout(cap_ok));
    dxh_sync u_s_bus  (.mclk(mclk), .rst(rst), .din(upstream_bus_pin), .dout(bus_high));

    dxh_state_t          state_r;
    dxh_state_t          state_nxt;
    logic [`DXH_CNTW-1:0] rsv_cnt_r;
    logic [`DXH_CNTW-1:0] to_cnt_r;
    logic [`DXH_CNTW-1:0] cap_cnt_r;
    logic [`DXH_CNTW-1:0] hold_cnt_r;
    logic [`DXH_CNTW-1:0] sw_cnt_r;
    logic                 st_on_r;
    logic                 lock_r;
    logic                 last_off_r;
    logic [`DXH_EVW-1:0]  stat_r;
    logic [`DXH_EVW-1:0]  mask_r;
    logic                 sw_en_r;
    logic                 reinit_r;

    // Shared command match on a given identifier only; the device address is checked separately.
    function automatic logic cmd_is(input logic [3:0] id, input logic [3:0] want);
        cmd_is = (id == want);
    endfunction

    wire supply_fault = !dreg_ok || !areg_ok;
    wire rsv_expired  = !cap_ok && (rsv_cnt_r >= RSV_PERIOD_CYC[`DXH_CNTW-1:0] - 1'b1);
    wire to_expired   = !bus_high && (to_cnt_r >= TO_PERIOD_CYC[`DXH_CNTW-1:0] - 1'b1);
    wire cap_expired  = cap_test_fail && (cap_cnt_r >= CAP_PERIOD_CYC[`DXH_CNTW-1:0] - 1'b1);
    wire reset_pulse  = rsv_expired || to_expired || cap_expired;
    wire in_reset     = (state_r != DXH_RUN);
    wire from_up      = cmd_valid && !cmd_downstream;
    wire is_rsvd14    = cmd_is(cmd_id, `DXH_CMD_RSVD14);
    wire is_revinit   = cmd_is(cmd_id, `DXH_CMD_REVINIT);
    wire addr_hit     = (cmd_addr == dev_addr);
    wire discard      = cmd_valid && (cmd_downstream || is_rsvd14 || is_revinit);
    wire is_clear     = cmd_is(cmd_id, `DXH_CMD_CLEAR);
    wire fault_now    = cap_test_fail || !bus_high || !cap_ok;
    wire reinit_ok    = !reinit_r || (is_clear && !fault_now);
    wire take         = from_up && !is_rsvd14 && !is_revinit && !in_reset && reinit_ok;
    wire cmd_clear    = take && is_clear;
    wire cmd_st_on    = take && addr_hit && (cmd_addr != `DXH_ADDR_GLOBAL)
                        && cmd_is(cmd_id, `DXH_CMD_ST_ON);
    wire cmd_st_off   = take && addr_hit && cmd_is(cmd_id, `DXH_CMD_ST_OFF);
    wire crc_err      = (factory_crc_fail && factory_sealed) || (user_crc_fail && user_sealed);
    wire any_err      = crc_err || temp_out_of_range;
    wire [`DXH_EVW-1:0] ev_vec = {cmd_st_off && last_off_r, discard, any_err,
                                  !cap_ok && !in_reset, reset_pulse || supply_fault};

    // Reset sequencing: held while a supply is low, pulsed on periodic faults.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            DXH_RUN:   if (supply_fault) state_nxt = DXH_HOLD;
                       else if (reset_pulse) state_nxt = DXH_PULSE;
            DXH_HOLD:  if (!supply_fault) state_nxt = DXH_PULSE;
            DXH_PULSE: if (supply_fault) state_nxt = DXH_HOLD;
                       else if (hold_cnt_r == `DXH_HOLD_CYC - 1) state_nxt = DXH_RUN;
            default:   state_nxt = DXH_HOLD;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state_r <= DXH_HOLD;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            hold_cnt_r <= '0;
        else
            hold_cnt_r <= (state_r == DXH_PULSE) ? hold_cnt_r + 1'b1 : '0;
    end

    // silent until cleared
    // After any reset only a clear with no capacitor-test, bus or reserve fault is taken, so the device stays
    // silent between the periodic reset pulses of a lasting fault.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reinit_r <= 1'b1;
        else
            reinit_r <= in_reset || (reinit_r && !cmd_clear);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rsv_cnt_r <= '0;
        else
            rsv_cnt_r <= (cap_ok || rsv_expired || supply_fault) ? '0 : rsv_cnt_r + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            to_cnt_r <= '0;
        else
            to_cnt_r <= (bus_high || to_expired || supply_fault) ? '0 : to_cnt_r + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cap_cnt_r <= '0;
        else
            cap_cnt_r <= (!cap_test_fail || cap_expired) ? '0 : cap_cnt_r + 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sw_en_r  <= 1'b0;
            sw_cnt_r <= '0;
        end
        else if (in_reset)
        begin
            sw_en_r  <= 1'b0;
            sw_cnt_r <= '0;
        end
        else if (sw_cnt_r < `DXH_SWOPEN_CYC)
            sw_cnt_r <= sw_cnt_r + 1'b1;
        else
            sw_en_r <= 1'b1;
    end

    // self-test lockout
    // A reserve dip clears the lockout and the last-off record; self-test itself stays as commanded.
    wire st_on_nxt = (in_reset || cmd_clear || cmd_st_off) ? 1'b0 :
                     cmd_st_on ? !lock_r : st_on_r;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            st_on_r    <= 1'b0;
            lock_r     <= 1'b0;
            last_off_r <= 1'b0;
        end
        else
        begin
            st_on_r <= st_on_nxt;
            if (in_reset || !cap_ok || cmd_clear)
            begin
                lock_r     <= 1'b0;
                last_off_r <= 1'b0;
            end
            else if (cmd_st_off)
            begin
                lock_r     <= lock_r || last_off_r;
                last_off_r <= 1'b1;
            end
            else if (take && addr_hit)
                last_off_r <= 1'b0;
        end
    end

    // Interrupt status: set wins over a write-one clear.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            stat_r <= '0;
            mask_r <= '0;
        end
        else
        begin
            stat_r <= (stat_r & ~((reg_wr && reg_addr == `DXH_ADR_STAT) ?
                      reg_wdata[`DXH_EVW-1:0] : '0)) | ev_vec;
            if (reg_wr && reg_addr == `DXH_ADR_MASK)
                mask_r <= reg_wdata[`DXH_EVW-1:0];
        end
    end

    wire [7:0] flag_word = {3'h0, lock_r, crc_err, any_err, st_on_r, !cap_ok};
    wire [7:0] rd_mux = (reg_addr == `DXH_ADR_STAT)  ? {3'h0, stat_r} :
                        (reg_addr == `DXH_ADR_MASK)  ? {3'h0, mask_r} :
                        (reg_addr == `DXH_ADR_FLAGS) ? flag_word :
                        (reg_addr == `DXH_ADR_CTRL)  ? {5'h0, state_r} : 8'h00;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end

    wire err_hit = any_err;
    // error data choice
    // The response to a self-test command already shows the new self-test state.
    wire dsel_self = st_on_nxt;
    wire short_zero = any_err || (!cap_ok && !st_on_nxt);
    dxh_dsel_t dsel_nxt;
    assign dsel_nxt = (cmd_short && short_zero) ? DXH_DATA_ZERO :
                      dsel_self ? DXH_DATA_SELF : DXH_DATA_NORMAL;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            error_flag        <= 1'b0;
            selfcheck_on_flag <= 1'b0;
            reserve_low_flag  <= 1'b0;
            acc_data_sel      <= DXH_DATA_ZERO;
            resp_enable       <= 1'b0;
        end
        else
        begin
            error_flag        <= err_hit;
            selfcheck_on_flag <= st_on_nxt;
            reserve_low_flag  <= !cap_ok;
            acc_data_sel      <= dsel_nxt;
            resp_enable       <= take;
        end
    end

    assign cmd_accept       = take;
    assign selftest_drive   = st_on_r;
    assign bus_switch_close = sw_en_r && !in_reset;
    assign core_reset       = in_reset;
    assign irq              = |(stat_r & mask_r);

    AST_NO_RSVD: assert property (@(posedge mclk) disable iff (rst)
        (cmd_valid && cmd_id == `DXH_CMD_RSVD14) |-> !cmd_accept ##1 !resp_enable)
        else $error("Reserved identifier was answered.");
    AST_NO_REVINIT: assert property (@(posedge mclk) disable iff (rst)
        (cmd_valid && cmd_id == `DXH_CMD_REVINIT) |=> !resp_enable)
        else $error("Reverse initialization was answered.");
    AST_DOWNSTREAM: assert property (@(posedge mclk) disable iff (rst)
        (cmd_valid && cmd_downstream) |-> !cmd_accept)
        else $error("Downstream command was accepted.");
    AST_SUPPLY_SW: assert property (@(posedge mclk) disable iff (rst)
        $fell(dreg_ok && areg_ok) |-> ##[0:2] !bus_switch_close && core_reset)
        else $error("Switch stayed closed on supply fault.");
    AST_RSV_PERIOD: assert property (@(posedge mclk) disable iff (rst)
        rsv_expired && !supply_fault |=> state_r == DXH_PULSE)
        else $error("Reserve timeout did not reset.");
    AST_CAP_PERIOD: assert property (@(posedge mclk) disable iff (rst)
        cap_expired && !supply_fault && !in_reset |=> core_reset)
        else $error("Capacitor fault did not reset.");
    AST_TO_SILENT: assert property (@(posedge mclk) disable iff (rst)
        to_expired && !supply_fault && !in_reset |=> core_reset && !bus_switch_close)
        else $error("Frame timeout did not reset.");
    AST_ERR_ZERO: assert property (@(posedge mclk) disable iff (rst)
        (any_err && cmd_short) |=> acc_data_sel == DXH_DATA_ZERO && error_flag)
        else $error("Short data not zero under error.");
    AST_LOCKOUT: assert property (@(posedge mclk) disable iff (rst)
        lock_r && !cmd_clear |=> !st_on_r)
        else $error("Self-test active under lockout.");
endmodule

/* hdl/dxh_cfg.svh */
// Constant definitions for the sensor exception handler.
`ifndef DXH_CFG_SVH
`define DXH_CFG_SVH
`define DXH_CLK_MHZ          40
`define DXH_CMD_RSVD14       4'hE
`define DXH_CMD_REVINIT      4'hF
`define DXH_CMD_CLEAR        4'h0
`define DXH_CMD_ST_ON        4'hD
`define DXH_CMD_ST_OFF       4'hC
`define DXH_CMD_READ_ACC     4'h1
`define DXH_ADDR_GLOBAL      4'h0
`define DXH_SWOPEN_US        2
`define DXH_SWOPEN_CYC       (`DXH_SWOPEN_US * `DXH_CLK_MHZ)
`define DXH_RSV_PERIOD_US    1000
`define DXH_CAP_PERIOD_US    1000
`define DXH_TO_PERIOD_US     1000
`define DXH_US_TO_CYC(x)     ((x) * `DXH_CLK_MHZ)
`define DXH_HOLD_CYC         16
`define DXH_ADR_STAT         4'h0
`define DXH_ADR_MASK         4'h1
`define DXH_ADR_FLAGS        4'h2
`define DXH_ADR_CTRL         4'h3
`define DXH_EVW              5
`define DXH_EV_RESET         0
`define DXH_EV_RSVLOW        1
`define DXH_EV_ERROR         2
`define DXH_EV_DISCARD       3
`define DXH_EV_LOCKOUT       4
`define DXH_CNTW             24
`endif

/* hdl/dxh_pkg.sv */
// Types shared by the sensor exception handler.
package dxh_pkg;
    typedef enum logic [2:0]
    {
        DXH_RUN   = 3'b001,
        DXH_HOLD  = 3'b010,
        DXH_PULSE = 3'b100
    } dxh_state_t;
    typedef enum logic [1:0]
    {
        DXH_DATA_ZERO   = 2'h0,
        DXH_DATA_NORMAL = 2'h1,
        DXH_DATA_SELF   = 2'h2
    } dxh_dsel_t;
endpackage

/* hdl/dxh_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module dxh_sync
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic din,
    output logic      dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                dout <= s3_r;
        end
    end
endmodule

/* testbench/dxh_master.sv */
// Behavioural model of the bus master that sends decoded commands.
`timescale 1ns/1ps
`include "dxh_cfg.svh"
module dxh_master
(
    input  wire logic       mclk,
    input  wire logic       core_reset,
    input  wire logic       cmd_accept,
    output logic            cmd_valid,
    output logic            cmd_downstream,
    output logic [3:0]      cmd_id,
    output logic [3:0]      cmd_addr,
    output logic            cmd_short
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_downstream = 1'b0;
        cmd_id = 4'h0;
        cmd_addr = 4'h0;
        cmd_short = 1'b0;
    end
    // Fields are scrambled after the pulse so that stale values never look valid.
    task automatic send(input logic [3:0] id, input logic [3:0] a, input logic s,
                        input logic d, output logic acc);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_id <= id;
        cmd_addr <= a;
        cmd_short <= s;
        cmd_downstream <= d;
        @(negedge mclk);
        acc = cmd_accept;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_id <= ~id;
        cmd_addr <= ~a;
        cmd_short <= ~s;
        cmd_downstream <= ~d;
    endtask
    task automatic reinit(input logic [3:0] a, output logic acc);
        int n;
        n = 0;
        while (core_reset !== 1'b0 && n < 2000)
        begin
            @(negedge mclk);
            n++;
        end
        send(`DXH_CMD_CLEAR, a, 1'b0, 1'b0, acc);
    endtask
endmodule

/* testbench/tb_dxh_exception.sv */
// Self-checking bench for the sensor exception handler.
`timescale 1ns/1ps
`include "dxh_cfg.svh"
module tb_dxh_exception;
    import dxh_pkg::*;
    logic        mclk, rst, cmd_valid, cmd_downstream, cmd_short, dreg_low_n, areg_low_n;
    logic        reserve_cap_pin, upstream_bus_pin, cap_test_fail, factory_crc_fail;
    logic        factory_sealed, user_crc_fail, user_sealed, temp_out_of_range, reg_wr;
    logic        reg_rd, irq, cmd_accept, resp_enable, error_flag, selfcheck_on_flag, a;
    logic        reserve_low_flag, selftest_drive, bus_switch_close, core_reset, opn, prv;
    logic [3:0]  cmd_id, cmd_addr, dev_addr, reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, lfsr;
    dxh_dsel_t   acc_data_sel;
    int          error_cnt, checked, cyc, st, lck, lastc, err, rsv, rises;

    dxh_exception #(.RSV_PERIOD_CYC(50), .CAP_PERIOD_CYC(50), .TO_PERIOD_CYC(50)) u_dut
    (
        .mclk, .rst, .cmd_valid, .cmd_downstream, .cmd_id, .cmd_addr, .cmd_short, .dev_addr,
        .dreg_low_n, .areg_low_n, .reserve_cap_pin, .upstream_bus_pin, .cap_test_fail,
        .factory_crc_fail, .factory_sealed, .user_crc_fail, .user_sealed, .temp_out_of_range,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .cmd_accept, .resp_enable,
        .error_flag, .selfcheck_on_flag, .reserve_low_flag, .acc_data_sel, .selftest_drive,
        .bus_switch_close, .core_reset
    );
    dxh_master u_master
    (
        .mclk, .core_reset, .cmd_accept, .cmd_valid, .cmd_downstream, .cmd_id, .cmd_addr,
        .cmd_short
    );

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("rdata", reg_rdata, e);
    endtask
    // The model predicts acceptance for each command, and flags and data selection for accepted commands other than a clear.
    task automatic cmd(input logic [3:0] id, input logic s, input logic d);
        logic ea;
        u_master.send(id, dev_addr, s, d, a);
        ea = !d && id != `DXH_CMD_RSVD14 && id != `DXH_CMD_REVINIT;
        @(negedge mclk);
        chk("accept", a, ea);
        chk("resp", resp_enable, ea);
        if (!ea || id == `DXH_CMD_CLEAR)
        begin
            lck = ea ? 0 : lck;
            lastc = ea ? 0 : lastc;
            return;
        end
        st = (id == `DXH_CMD_ST_ON) ? !lck : (id == `DXH_CMD_ST_OFF) ? 0 : st;
        lck = (id == `DXH_CMD_ST_OFF) ? (lck | lastc) : lck;
        lastc = (id == `DXH_CMD_ST_OFF);
        chk("S", error_flag, err);
        chk("ST", selfcheck_on_flag, st);
        chk("U", reserve_low_flag, rsv);
        chk("drive", selftest_drive, st);
        chk("sel", acc_data_sel, st ? ((err && s) ? 0 : 2) : (((err || rsv) && s) ? 0 : 1));
    endtask
    task automatic faults(input logic [7:0] r);
        @(posedge mclk);
        temp_out_of_range <= r[0];
        factory_crc_fail <= r[1];
        factory_sealed <= r[2];
        user_crc_fail <= r[3];
        user_sealed <= r[4];
        err = r[0] | (r[1] & r[2]) | (r[3] & r[4]);
        repeat (2) @(negedge mclk);
    endtask
    task automatic setf(input int k, input logic v);
        @(posedge mclk);
        dreg_low_n <= !(v && k == 0);
        areg_low_n <= !(v && k == 1);
        cap_test_fail <= v && k == 2;
        upstream_bus_pin <= !(v && k == 3);
        reserve_cap_pin <= !(v && k == 4);
    endtask
    task automatic rnd_reads;
        repeat (12)
        begin
            lfsr = nxt(lfsr);
            faults(lfsr);
            cmd(`DXH_CMD_READ_ACC, lfsr[5], 1'b0);
        end
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            results();
        end
    end
    initial
    begin
        rst = 1'b1;
        lfsr = 8'h62;
        dev_addr = lfsr[3:0] | 4'h1;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {dreg_low_n, areg_low_n, reserve_cap_pin, upstream_bus_pin} = 4'hF;
        {cap_test_fail, factory_crc_fail, factory_sealed, user_crc_fail, user_sealed} = '0;
        temp_out_of_range = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (400) @(negedge mclk);
        chk("up", core_reset, 0);
        rd(`DXH_ADR_CTRL, 8'h01);
        cmd(`DXH_CMD_CLEAR, 1'b0, 1'b0);
        cmd(`DXH_CMD_ST_ON, 1'b0, 1'b0);
        cmd(`DXH_CMD_ST_OFF, 1'b0, 1'b0);
        cmd(`DXH_CMD_ST_OFF, 1'b0, 1'b0);
        cmd(`DXH_CMD_ST_ON, 1'b1, 1'b0);
        rd(`DXH_ADR_FLAGS, 8'h10);
        cmd(`DXH_CMD_CLEAR, 1'b0, 1'b0);
        cmd(`DXH_CMD_ST_ON, 1'b0, 1'b0);
        rnd_reads();
        cmd(`DXH_CMD_ST_OFF, 1'b0, 1'b0);
        rnd_reads();
        faults(8'h00);
        wr(`DXH_ADR_STAT, 8'hFF);
        wr(`DXH_ADR_MASK, 8'h08);
        rd(`DXH_ADR_MASK, 8'h08);
        chk("irq", irq, 0);
        cmd(`DXH_CMD_RSVD14, 1'b0, 1'b0);
        cmd(`DXH_CMD_REVINIT, 1'b1, 1'b0);
        cmd(`DXH_CMD_ST_ON, 1'b0, 1'b1);
        cmd(`DXH_CMD_READ_ACC, 1'b1, 1'b0);
        chk("irq", irq, 1);
        rd(`DXH_ADR_STAT, 8'h08);
        wr(`DXH_ADR_MASK, 8'h00);
        chk("irq", irq, 0);
        wr(`DXH_ADR_STAT, 8'h08);
        rd(`DXH_ADR_STAT, 8'h00);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        rd(`DXH_ADR_MASK, 8'h00);
        cmd(`DXH_CMD_CLEAR, 1'b0, 1'b0);
        for (int s = 0; s < 2; s++)
        begin
            cmd(s ? `DXH_CMD_ST_ON : `DXH_CMD_ST_OFF, 1'b0, 1'b0);
            setf(4, 1'b1);
            rsv = 1;
            repeat (6) @(negedge mclk);
            cmd(`DXH_CMD_READ_ACC, 1'b1, 1'b0);
            cmd(`DXH_CMD_READ_ACC, 1'b0, 1'b0);
            setf(4, 1'b0);
            rsv = 0;
            repeat (30) @(negedge mclk);
            chk("noreset", core_reset, 0);
        end
        faults(8'h01);
        for (int k = 0; k < 5; k++)
        begin
            setf(k, 1'b1);
            rises = 0;
            opn = 1'b0;
            prv = core_reset;
            for (int i = 0; i < 180; i++)
            begin
                @(negedge mclk);
                rises += int'(core_reset && !prv);
                prv = core_reset;
                opn |= (i > 150) && bus_switch_close;
            end
            chk("open", opn, 0);
            chk("repeat", k < 2 || rises >= 2, 1);
            chk("held", k > 1 || core_reset, 1);
            u_master.send(`DXH_CMD_READ_ACC, dev_addr, 1'b0, 1'b0, a);
            chk("silent", a, 0);
            setf(k, 1'b0);
            repeat (8) @(negedge mclk);
            u_master.reinit(dev_addr, a);
            chk("reinit", a, 1);
            lck = 0;
            lastc = 0;
            cmd(`DXH_CMD_ST_OFF, 1'b1, 1'b0);
        end
        results();
    end
endmodule
